// file: common/waveform_timer_params.svh
`ifndef WAVEFORM_TIMER_PARAMS_SVH
`define WAVEFORM_TIMER_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define WT_ADDR_W 5
`define WT_DATA_W 8
`define WT_CNT_W 12

// ----------------------------------------
// Register map
// ----------------------------------------
`define WT_ADDR_FIRST_CTRL 5'h00
`define WT_ADDR_SECOND_CTRL 5'h01
`define WT_ADDR_THIRD_CTRL 5'h02
`define WT_ADDR_COMMAND 5'h03
`define WT_ADDR_FAULT_CTRL 5'h04
`define WT_ADDR_STATUS 5'h05
`define WT_ADDR_BLANK_CTRL 5'h06
`define WT_ADDR_BLANK_LEN 5'h07
`define WT_ADDR_SET_A_LO 5'h08
`define WT_ADDR_SET_A_HI 5'h09
`define WT_ADDR_CLR_A_LO 5'h0a
`define WT_ADDR_CLR_A_HI 5'h0b
`define WT_ADDR_SET_B_LO 5'h0c
`define WT_ADDR_SET_B_HI 5'h0d
`define WT_ADDR_CLR_B_LO 5'h0e
`define WT_ADDR_CLR_B_HI 5'h0f
`define WT_ADDR_COUNT_LO 5'h10
`define WT_ADDR_COUNT_HI 5'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WT_ENABLE_BIT 0
`define WT_AUTO_UPDATE_BIT 0
`define WT_CMD_SYNC_BIT 0
`define WT_CMD_EOC_BIT 1
`define WT_FAULT_ASYNC_BIT 0
`define WT_FAULT_SYNC_BIT 1
`define WT_BLANK_EN_BIT 2
`define WT_ST_ENABLE_READY 0
`define WT_ST_COMMAND_READY 1
`define WT_ST_BUFFER_READY 2
`define WT_ST_RUNNING 3

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define WT_BYTE_RESET 8'h00
`define WT_CNT_RESET 12'h000
`define WT_XFER_RESET 2'h0
`define WT_XFER_CYCLES 2'h2

`endif

// file: common/waveform_timer_pkg.sv
package waveform_timer_pkg;

typedef enum logic [3:0] {
	DEAD_A = 4'b0001,
	ON_A = 4'b0010,
	DEAD_B = 4'b0100,
	ON_B = 4'b1000
} cycle_state_type;

typedef enum logic [1:0] {
	ONE_RAMP = 2'h0,
	TWO_RAMP = 2'h1,
	FOUR_RAMP = 2'h2,
	DUAL_SLOPE = 2'h3
} waveform_mode_type;

typedef struct packed {
	logic [11:0] set_a;
	logic [11:0] clear_a;
	logic [11:0] set_b;
	logic [11:0] clear_b;
} compare_set_type;

endpackage : waveform_timer_pkg

// file: logic/waveform_timer.sv
// What this block does
// (R1) One-ramp: count up to clear-B, end cycle, restart at zero.
// (R2) Two-ramp: counter returns to zero twice per cycle.
// (R3) Four-ramp: counter returns to zero four times per cycle.
// (R4) Dual-slope: counter runs down to zero and up to clear-B.
// (R5) Cycle walks dead A, on A, dead B, on B; compares end states.
// (R6) Mode select field in second control register picks four modes.
// (R7) Enable bit changes only while enable-ready reads one.
// (R8) Other first-control bits written only while enable is zero.
// (R9) Fault control changes only through the timed protection procedure.
// (R10) Command register carried to core when enabled and idle.
// (R11) Command register clears itself once the command is taken for transfer to the core.
// (R12) Buffered registers writable only while buffered-update-ready reads one.
// (R13) Buffered values move to core on sync command or enable.
// (R14) Auto update: clear-B high byte write schedules end-of-cycle transfer.
// (R15) Immediate sync command transfers once on reaching the core.
// (R16) End-of-cycle sync command transfers at end of next cycle.
// (R17) Sync commands ignored while a buffered transfer is pending.
// (R18) Static registers refuse writes while enabled.
// (R19) Software initializes static, then compares, then enables.
// (R20) Software orders one-ramp compares to avoid overlapping on-times.
// (R21) Asynchronous fault control overrides outputs at once.
// (R22) Blanking ignores synchronous faults for a programmed time after a chosen state.
// (R23) Core side sees enable and command values only after a transfer delay; static registers and blank control act at once.
// (R24) Counter and compares twelve bits, wrapping after terminal match.
//
// Chosen here: the placing of the registers and strobed register access.
`include "waveform_timer_params.svh"
`timescale 1ns/100ps
`default_nettype none

module waveform_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port
	input wire logic [`WT_ADDR_W-1:0] reg_address,
	input wire logic [`WT_DATA_W-1:0] reg_write_data,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [`WT_DATA_W-1:0] reg_read_data,
	// Protection unlock from the timed write procedure
	input wire logic config_change_unlock,
	// Fault event pin
	input wire logic fault_event,
	// Waveform pins
	output logic waveform_out_a,
	output logic waveform_out_b
);

// ----------------------------------------
// Declarations
// ----------------------------------------
logic enable;
logic [`WT_DATA_W-1:0] first_control_register;
logic [`WT_DATA_W-1:0] second_control_register;
logic [`WT_DATA_W-1:0] third_control_register;
logic [`WT_DATA_W-1:0] command_register;
logic [`WT_DATA_W-1:0] fault_control_register;
logic [`WT_DATA_W-1:0] blank_control;
logic [`WT_DATA_W-1:0] blank_length;
waveform_timer_pkg::compare_set_type shadow;
waveform_timer_pkg::compare_set_type active;
logic [`WT_DATA_W-1:0] active_blank_length;
logic [1:0] enable_xfer;
logic [1:0] command_xfer;
logic [`WT_DATA_W-1:0] command_in_flight;
logic core_enable;
logic buffer_pending;
logic [`WT_CNT_W-1:0] counter;
logic count_down;
waveform_timer_pkg::cycle_state_type state;
logic dual_a;
logic dual_b;
logic fault_meta;
logic fault_sync;
logic [`WT_DATA_W-1:0] blank_count;
logic blanking;
logic enable_ready_flag;
logic command_ready_flag;
logic buffered_update_ready_flag;
logic wr_first;
logic wr_static;
logic wr_buffered;
logic command_delivered;
logic immediate_sync;
logic end_cycle_sync_command;
logic enable_rise;
logic end_of_cycle;
logic async_kill;
waveform_timer_pkg::waveform_mode_type waveform_mode_select;
logic auto_update_on_write;
logic [`WT_CNT_W-1:0] next_counter;
logic next_count_down;
waveform_timer_pkg::cycle_state_type next_state;
logic state_match;

// ----------------------------------------
// Helpers
// ----------------------------------------
function automatic logic [`WT_CNT_W-1:0] compare_of(
	input waveform_timer_pkg::cycle_state_type s,
	input waveform_timer_pkg::compare_set_type c
);
	unique case (s)
		waveform_timer_pkg::DEAD_A: compare_of = c.set_a;
		waveform_timer_pkg::ON_A: compare_of = c.clear_a;
		waveform_timer_pkg::DEAD_B: compare_of = c.set_b;
		waveform_timer_pkg::ON_B: compare_of = c.clear_b;
		default: compare_of = c.clear_b;
	endcase
endfunction : compare_of

function automatic waveform_timer_pkg::cycle_state_type advance(
	input waveform_timer_pkg::cycle_state_type s
);
	unique case (s)
		waveform_timer_pkg::DEAD_A: advance = waveform_timer_pkg::ON_A;
		waveform_timer_pkg::ON_A: advance = waveform_timer_pkg::DEAD_B;
		waveform_timer_pkg::DEAD_B: advance = waveform_timer_pkg::ON_B;
		waveform_timer_pkg::ON_B: advance = waveform_timer_pkg::DEAD_A;
		default: advance = waveform_timer_pkg::DEAD_A;
	endcase
endfunction : advance

function automatic logic [`WT_CNT_W-1:0] merge_byte(
	input logic [`WT_CNT_W-1:0] old,
	input logic [`WT_DATA_W-1:0] data,
	input logic high
);
	if (high) begin
		merge_byte = {data[3:0], old[7:0]};
	end else begin
		merge_byte = {old[11:8], data};
	end
endfunction : merge_byte

// ----------------------------------------
// Decode
// ----------------------------------------
assign enable = first_control_register[`WT_ENABLE_BIT];
assign waveform_mode_select =
	waveform_timer_pkg::waveform_mode_type'(second_control_register[1:0]); // R6
assign auto_update_on_write = third_control_register[`WT_AUTO_UPDATE_BIT];
assign enable_ready_flag = (enable_xfer == `WT_XFER_RESET);
assign command_ready_flag = (command_xfer == `WT_XFER_RESET)
	&& (command_register == `WT_BYTE_RESET);
assign buffered_update_ready_flag = !buffer_pending
	&& (command_xfer == `WT_XFER_RESET); // R12
assign wr_first = reg_write && (reg_address == `WT_ADDR_FIRST_CTRL);
assign wr_static = reg_write && !enable; // R18
assign wr_buffered = reg_write && buffered_update_ready_flag; // R12
assign command_delivered = (command_xfer == 2'h1); // R23
assign immediate_sync = command_delivered
	&& command_in_flight[`WT_CMD_SYNC_BIT];
assign end_cycle_sync_command = command_delivered
	&& command_in_flight[`WT_CMD_EOC_BIT];
assign enable_rise = (enable_xfer == 2'h1) && enable && !core_enable;
assign async_kill = fault_event
	&& fault_control_register[`WT_FAULT_ASYNC_BIT]; // R21

// ----------------------------------------
// Control registers
// ----------------------------------------
always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		first_control_register <= `WT_BYTE_RESET;
	end else if (wr_first) begin
		if (enable_ready_flag) begin
			first_control_register[`WT_ENABLE_BIT] <=
				reg_write_data[`WT_ENABLE_BIT]; // R7
		end
		if (!enable) begin
			first_control_register[7:1] <= reg_write_data[7:1]; // R8
		end
	end
end

always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		second_control_register <= `WT_BYTE_RESET;
		third_control_register <= `WT_BYTE_RESET;
		fault_control_register <= `WT_BYTE_RESET;
	end else if (wr_static) begin
		if (reg_address == `WT_ADDR_SECOND_CTRL) begin
			second_control_register <= reg_write_data;
		end
		if (reg_address == `WT_ADDR_THIRD_CTRL) begin
			third_control_register <= reg_write_data;
		end
		if (reg_address == `WT_ADDR_FAULT_CTRL && config_change_unlock) begin
			fault_control_register <= reg_write_data; // R9
		end
	end
end

// ----------------------------------------
// Buffered registers, bus side
// ----------------------------------------
always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		shadow <= '0;
		blank_control <= `WT_BYTE_RESET;
		blank_length <= `WT_BYTE_RESET;
	end else if (wr_buffered) begin
		unique case (reg_address)
			`WT_ADDR_SET_A_LO, `WT_ADDR_SET_A_HI: begin
				shadow.set_a <= merge_byte(shadow.set_a, reg_write_data,
					reg_address[0]);
			end
			`WT_ADDR_CLR_A_LO, `WT_ADDR_CLR_A_HI: begin
				shadow.clear_a <= merge_byte(shadow.clear_a, reg_write_data,
					reg_address[0]);
			end
			`WT_ADDR_SET_B_LO, `WT_ADDR_SET_B_HI: begin
				shadow.set_b <= merge_byte(shadow.set_b, reg_write_data,
					reg_address[0]);
			end
			`WT_ADDR_CLR_B_LO, `WT_ADDR_CLR_B_HI: begin
				shadow.clear_b <= merge_byte(shadow.clear_b, reg_write_data,
					reg_address[0]);
			end
			`WT_ADDR_BLANK_CTRL: blank_control <= reg_write_data;
			`WT_ADDR_BLANK_LEN: blank_length <= reg_write_data;
			default: ;
		endcase
	end
end

// ----------------------------------------
// Enable and command transfer
// ----------------------------------------
always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		enable_xfer <= `WT_XFER_RESET;
		core_enable <= 1'b0;
	end else if (wr_first && enable_ready_flag
		&& reg_write_data[`WT_ENABLE_BIT] != enable) begin
		enable_xfer <= `WT_XFER_CYCLES; // R7
	end else if (enable_xfer != `WT_XFER_RESET) begin
		enable_xfer <= enable_xfer - 2'h1;
		if (enable_xfer == 2'h1) begin
			core_enable <= enable; // R23
		end
	end
end

always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		command_register <= `WT_BYTE_RESET;
		command_in_flight <= `WT_BYTE_RESET;
		command_xfer <= `WT_XFER_RESET;
	end else if (command_xfer != `WT_XFER_RESET) begin
		command_xfer <= command_xfer - 2'h1;
	end else if (core_enable && command_register != `WT_BYTE_RESET) begin
		command_in_flight <= command_register; // R10
		command_register <= `WT_BYTE_RESET; // R11
		command_xfer <= `WT_XFER_CYCLES;
	end else if (reg_write && reg_address == `WT_ADDR_COMMAND) begin
		command_register <= reg_write_data;
	end
end

// ----------------------------------------
// Buffered transfer into the core
// ----------------------------------------
always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		active <= '0;
		active_blank_length <= `WT_BYTE_RESET;
		buffer_pending <= 1'b0;
	end else if (enable_rise || (immediate_sync && !buffer_pending)) begin
		active <= shadow; // R13 R15 R17
		active_blank_length <= blank_length;
	end else if (buffer_pending && end_of_cycle) begin
		active <= shadow; // R14 R16
		active_blank_length <= blank_length;
		buffer_pending <= 1'b0;
	end else if (end_cycle_sync_command
		|| (wr_buffered && auto_update_on_write
		&& reg_address == `WT_ADDR_CLR_B_HI)) begin
		buffer_pending <= 1'b1; // R14 R16 R17
	end
end

// ----------------------------------------
// Counter next value
// ----------------------------------------
always_comb begin
	state_match = (counter == compare_of(state, active));
	next_counter = counter + 12'h001;
	next_count_down = count_down;
	next_state = state;
	end_of_cycle = 1'b0;
	unique case (waveform_mode_select)
		waveform_timer_pkg::ONE_RAMP: begin
			if (counter == active.clear_b) begin
				next_counter = `WT_CNT_RESET; // R1 R24
				next_state = waveform_timer_pkg::DEAD_A;
				end_of_cycle = 1'b1;
			end else if (state_match) begin
				next_state = advance(state); // R5
			end
		end
		waveform_timer_pkg::TWO_RAMP: begin
			if (state == waveform_timer_pkg::DEAD_A
				|| state == waveform_timer_pkg::ON_A) begin
				if (counter == active.clear_a) begin
					next_counter = `WT_CNT_RESET; // R2
					next_state = waveform_timer_pkg::DEAD_B;
				end else if (state_match) begin
					next_state = waveform_timer_pkg::ON_A;
				end
			end else if (counter == active.clear_b) begin
				next_counter = `WT_CNT_RESET; // R2
				next_state = waveform_timer_pkg::DEAD_A;
				end_of_cycle = 1'b1;
			end else if (state_match) begin
				next_state = waveform_timer_pkg::ON_B;
			end
		end
		waveform_timer_pkg::FOUR_RAMP: begin
			if (state_match) begin
				next_counter = `WT_CNT_RESET; // R3
				next_state = advance(state); // R5
				end_of_cycle = (state == waveform_timer_pkg::ON_B);
			end
		end
		waveform_timer_pkg::DUAL_SLOPE: begin
			if (count_down) begin
				next_counter = counter - 12'h001;
				if (counter == `WT_CNT_RESET) begin
					next_counter = counter; // R4
					next_count_down = 1'b0;
				end
			end else if (counter == active.clear_b) begin
				next_counter = counter; // R4
				next_count_down = 1'b1;
				end_of_cycle = 1'b1;
			end
			if (count_down) begin
				next_state = dual_a ? waveform_timer_pkg::ON_A
					: waveform_timer_pkg::DEAD_A;
			end else begin
				next_state = dual_b ? waveform_timer_pkg::ON_B
					: waveform_timer_pkg::DEAD_B;
			end
		end
	endcase
end

// ----------------------------------------
// Counter core
// ----------------------------------------
always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		counter <= `WT_CNT_RESET;
		count_down <= 1'b0;
		state <= waveform_timer_pkg::DEAD_A;
	end else if (enable_rise) begin
		counter <= (waveform_mode_select == waveform_timer_pkg::DUAL_SLOPE)
			? shadow.clear_b : `WT_CNT_RESET; // R4
		count_down <= (waveform_mode_select == waveform_timer_pkg::DUAL_SLOPE);
		state <= waveform_timer_pkg::DEAD_A;
	end else if (core_enable) begin
		counter <= next_counter;
		count_down <= next_count_down;
		state <= next_state;
	end
end

always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		dual_a <= 1'b0;
		dual_b <= 1'b0;
	end else if (!core_enable || enable_rise) begin
		dual_a <= 1'b0;
		dual_b <= 1'b0;
	end else begin
		if (counter == active.set_a) begin
			dual_a <= count_down; // R4
		end
		if (counter == active.set_b) begin
			dual_b <= !count_down; // R4
		end
	end
end

// ----------------------------------------
// Fault input and blanking
// ----------------------------------------
always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		fault_meta <= 1'b0;
		fault_sync <= 1'b0;
	end else begin
		fault_meta <= fault_event;
		fault_sync <= fault_meta;
	end
end

always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		blank_count <= `WT_BYTE_RESET;
		blanking <= 1'b0;
	end else if (core_enable && blank_control[`WT_BLANK_EN_BIT]
		&& next_state != state
		&& next_state[blank_control[1:0]]) begin
		blank_count <= `WT_BYTE_RESET; // R22
		blanking <= (active_blank_length != `WT_BYTE_RESET);
	end else if (blanking) begin
		blank_count <= blank_count + 8'h01;
		if (blank_count + 8'h01 >= active_blank_length) begin
			blanking <= 1'b0; // R22
		end
	end
end

// ----------------------------------------
// Waveform outputs
// ----------------------------------------
always_ff @(posedge sys_clk or posedge reset or posedge async_kill) begin
	if (reset || async_kill) begin
		waveform_out_a <= 1'b0; // R21
		waveform_out_b <= 1'b0;
	end else if (!core_enable || (fault_sync && !blanking
		&& fault_control_register[`WT_FAULT_SYNC_BIT])) begin
		waveform_out_a <= 1'b0; // R22
		waveform_out_b <= 1'b0;
	end else begin
		waveform_out_a <= (next_state == waveform_timer_pkg::ON_A); // R5
		waveform_out_b <= (next_state == waveform_timer_pkg::ON_B);
	end
end

// ----------------------------------------
// Read port
// ----------------------------------------
always_ff @(posedge sys_clk or posedge reset) begin
	if (reset) begin
		reg_read_data <= `WT_BYTE_RESET;
	end else if (reg_read) begin
		unique case (reg_address)
			`WT_ADDR_FIRST_CTRL: reg_read_data <= first_control_register;
			`WT_ADDR_SECOND_CTRL: reg_read_data <= second_control_register;
			`WT_ADDR_THIRD_CTRL: reg_read_data <= third_control_register;
			`WT_ADDR_COMMAND: reg_read_data <= command_register;
			`WT_ADDR_FAULT_CTRL: reg_read_data <= fault_control_register;
			`WT_ADDR_STATUS: reg_read_data <= {4'h0, core_enable,
				buffered_update_ready_flag, command_ready_flag,
				enable_ready_flag};
			`WT_ADDR_BLANK_CTRL: reg_read_data <= blank_control;
			`WT_ADDR_BLANK_LEN: reg_read_data <= blank_length;
			`WT_ADDR_SET_A_LO: reg_read_data <= shadow.set_a[7:0];
			`WT_ADDR_SET_A_HI: reg_read_data <= {4'h0, shadow.set_a[11:8]};
			`WT_ADDR_CLR_A_LO: reg_read_data <= shadow.clear_a[7:0];
			`WT_ADDR_CLR_A_HI: reg_read_data <= {4'h0, shadow.clear_a[11:8]};
			`WT_ADDR_SET_B_LO: reg_read_data <= shadow.set_b[7:0];
			`WT_ADDR_SET_B_HI: reg_read_data <= {4'h0, shadow.set_b[11:8]};
			`WT_ADDR_CLR_B_LO: reg_read_data <= shadow.clear_b[7:0];
			`WT_ADDR_CLR_B_HI: reg_read_data <= {4'h0, shadow.clear_b[11:8]};
			`WT_ADDR_COUNT_LO: reg_read_data <= counter[7:0];
			`WT_ADDR_COUNT_HI: reg_read_data <= {4'h0, counter[11:8]};
			default: reg_read_data <= `WT_BYTE_RESET;
		endcase
	end else begin
		reg_read_data <= `WT_BYTE_RESET;
	end
end

endmodule : waveform_timer

`default_nettype wire

// file: verification/waveform_timer_checker.sv
`include "waveform_timer_params.svh"
`timescale 1ns/100ps
`default_nettype none

module waveform_timer_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port
	input wire logic [`WT_ADDR_W-1:0] reg_address,
	input wire logic [`WT_DATA_W-1:0] reg_write_data,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [`WT_DATA_W-1:0] reg_read_data,
	// Unlock and fault pin
	input wire logic config_change_unlock,
	input wire logic fault_event,
	// Waveform pins
	input wire logic waveform_out_a,
	input wire logic waveform_out_b
);
	logic ever_enabled;
	logic kill_armed;
	logic enable_write;
	logic high_byte;

	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	assign enable_write = reg_write && reg_address == `WT_ADDR_FIRST_CTRL
		&& reg_write_data[`WT_ENABLE_BIT];
	assign high_byte = reg_address inside {`WT_ADDR_SET_A_HI,
		`WT_ADDR_CLR_A_HI, `WT_ADDR_SET_B_HI, `WT_ADDR_CLR_B_HI,
		`WT_ADDR_COUNT_HI};

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			ever_enabled <= 1'b0;
		else if (enable_write)
			ever_enabled <= 1'b1;
	end

	// Async kill bit; bench writes fault control only while disabled
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			kill_armed <= 1'b0;
		else if (reg_write && reg_address == `WT_ADDR_FAULT_CTRL
			&& config_change_unlock)
			kill_armed <= reg_write_data[`WT_FAULT_ASYNC_BIT];
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	AST_READ_IDLE_ZERO:
	assert property (!reg_read |=> reg_read_data == 8'h00)
		else $error("read data not zero outside a read");
	AST_UNMAPPED_ZERO:
	assert property (reg_read && reg_address > `WT_ADDR_COUNT_HI
		|=> reg_read_data == 8'h00)
		else $error("unmapped read not zero");
	AST_HIGH_NIBBLE:
	assert property (reg_read && high_byte |=> reg_read_data[7:4] == 4'h0)
		else $error("high byte upper nibble not zero");
	AST_STATUS_NIBBLE:
	assert property (reg_read && reg_address == `WT_ADDR_STATUS
		|=> reg_read_data[7:4] == 4'h0)
		else $error("status upper nibble not zero");
	AST_NO_OVERLAP:
	assert property (!(waveform_out_a && waveform_out_b))
		else $error("both outputs high");
	AST_QUIET_UNTIL_ENABLE:
	assert property (!ever_enabled |-> !waveform_out_a && !waveform_out_b)
		else $error("output before enable");
	AST_START_DELAY:
	assert property (enable_write && !ever_enabled
		|=> (!waveform_out_a && !waveform_out_b) [*2])
		else $error("output too soon after enable");
	AST_ASYNC_KILL:
	assert property (kill_armed && fault_event
		|-> !waveform_out_a && !waveform_out_b)
		else $error("output high during fault kill");

	cover property ($rose(waveform_out_a));
	cover property ($rose(waveform_out_b));
	cover property (kill_armed && fault_event);
	cover property (reg_read && reg_address == `WT_ADDR_STATUS);
endmodule : waveform_timer_checker

bind waveform_timer waveform_timer_checker checker_inst (
	.sys_clk(sys_clk),
	.reset(reset),
	.reg_address(reg_address),
	.reg_write_data(reg_write_data),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_read_data(reg_read_data),
	.config_change_unlock(config_change_unlock),
	.fault_event(fault_event),
	.waveform_out_a(waveform_out_a),
	.waveform_out_b(waveform_out_b)
);

`default_nettype wire

// file: verification/waveform_timer_tb.sv
`include "waveform_timer_params.svh"
`timescale 1ns/100ps
`default_nettype none

module waveform_timer_tb;
	logic sys_clk;
	logic reset;
	logic [`WT_ADDR_W-1:0] reg_address;
	logic [`WT_DATA_W-1:0] reg_write_data;
	logic reg_write;
	logic reg_read;
	logic [`WT_DATA_W-1:0] reg_read_data;
	logic config_change_unlock;
	logic fault_event;
	logic waveform_out_a;
	logic waveform_out_b;
	int err_count;
	int n_compared;
	int cycles;

	waveform_timer DUT (
		.sys_clk(sys_clk),
		.reset(reset),
		.reg_address(reg_address),
		.reg_write_data(reg_write_data),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_read_data(reg_read_data),
		.config_change_unlock(config_change_unlock),
		.fault_event(fault_event),
		.waveform_out_a(waveform_out_a),
		.waveform_out_b(waveform_out_b)
	);

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task complete_run();
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_address <= a;
		reg_write_data <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr

	// Two writes to one address on consecutive edges
	task wr2(input logic [4:0] a, input logic [7:0] d1, input logic [7:0] d2);
		@(posedge sys_clk);
		reg_address <= a;
		reg_write_data <= d1;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write_data <= d2;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr2

	task rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_address <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 d = reg_read_data;
	endtask : rd

	task rdchk(input string name, input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		check(name, {8'h00, d}, {8'h00, e});
	endtask : rdchk

	task wait_ready(input int b);
		logic [7:0] d;
		int k;
		d = 8'h00;
		k = 0;
		while (d[b] !== 1'b1 && k < 30) begin
			rd(`WT_ADDR_STATUS, d);
			k++;
		end
		check("status ready", {15'h0000, d[b]}, 16'h0001);
	endtask : wait_ready

	// Cycles until the selected output next rises
	task rise(input logic sel, output int c);
		c = 0;
		while ((sel ? waveform_out_b : waveform_out_a) !== 1'b0 && c < 300) begin
			@(negedge sys_clk);
			c++;
		end
		while ((sel ? waveform_out_b : waveform_out_a) !== 1'b1 && c < 300) begin
			@(negedge sys_clk);
			c++;
		end
	endtask : rise

	// Both outputs held low for n cycles
	task quiet(input string name, input int n);
		repeat (n) begin
			@(negedge sys_clk);
			check(name, {14'h0000, waveform_out_a, waveform_out_b}, 16'h0000);
		end
	endtask : quiet

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int exp_p[4];
		int c;
		logic [7:0] d;
		exp_p = '{12, 18, 30, 24};
		err_count = 0;
		n_compared = 0;
		reset = 1'b1;
		reg_address = 5'h00;
		reg_write_data = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		config_change_unlock = 1'b0;
		fault_event = 1'b0;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		rd(`WT_ADDR_STATUS, d);
		check("status after reset", {8'h00, d & 8'h09}, 16'h0001);
		wr(5'h1f, 8'hff);
		rdchk("unmapped", 5'h1f, 8'h00);
		wr(`WT_ADDR_FAULT_CTRL, 8'h01);
		rdchk("fault ctrl locked", `WT_ADDR_FAULT_CTRL, 8'h00);
		@(posedge sys_clk);
		config_change_unlock <= 1'b1;
		wr(`WT_ADDR_FAULT_CTRL, 8'h01);
		config_change_unlock <= 1'b0;
		rdchk("fault ctrl", `WT_ADDR_FAULT_CTRL, 8'h01);
		wr(`WT_ADDR_SET_A_LO, 8'h02);
		wr(`WT_ADDR_CLR_A_LO, 8'h05);
		wr(`WT_ADDR_SET_B_LO, 8'h08);
		wr(`WT_ADDR_CLR_B_LO, 8'h0b);
		wr(`WT_ADDR_CLR_B_HI, 8'hf0);
		rdchk("clear b low", `WT_ADDR_CLR_B_LO, 8'h0b);
		rdchk("clear b high", `WT_ADDR_CLR_B_HI, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(`WT_ADDR_SECOND_CTRL, 8'(m));
			rdchk("mode", `WT_ADDR_SECOND_CTRL, 8'(m));
			wait_ready(`WT_ST_ENABLE_READY);
			wr(`WT_ADDR_FIRST_CTRL, 8'h01);
			rise(1'b0, c);
			rise(1'b0, c);
			check("period", 16'(c), 16'(exp_p[m]));
			if (m == 0) begin
				rise(1'b1, c);
				check("a to b", 16'(c), 16'h0006);
			end
			wr(`WT_ADDR_SECOND_CTRL, 8'(m ^ 1));
			rdchk("static locked", `WT_ADDR_SECOND_CTRL, 8'(m));
			wr(`WT_ADDR_FIRST_CTRL, 8'h03);
			rdchk("protected bits", `WT_ADDR_FIRST_CTRL, 8'h01);
			wait_ready(`WT_ST_ENABLE_READY);
			wr(`WT_ADDR_FIRST_CTRL, 8'h00);
		end
		wait_ready(`WT_ST_ENABLE_READY);
		wr2(`WT_ADDR_FIRST_CTRL, 8'h01, 8'h00);
		rdchk("enable refused", `WT_ADDR_FIRST_CTRL, 8'h01);
		rise(1'b0, c);
		@(posedge sys_clk);
		fault_event <= 1'b1;
		quiet("kill", 3);
		@(posedge sys_clk);
		fault_event <= 1'b0;
		wait_ready(`WT_ST_BUFFER_READY);
		wr(`WT_ADDR_CLR_B_LO, 8'h0d);
		rise(1'b0, c);
		rise(1'b0, c);
		check("no sync", 16'(c), 16'h0018);
		wr(`WT_ADDR_COMMAND, 8'h01);
		rdchk("command clears", `WT_ADDR_COMMAND, 8'h00);
		repeat (3) rise(1'b0, c);
		check("sync now", 16'(c), 16'h001c);
		wait_ready(`WT_ST_COMMAND_READY);
		wait_ready(`WT_ST_BUFFER_READY);
		wr(`WT_ADDR_CLR_B_LO, 8'h0f);
		wr(`WT_ADDR_COMMAND, 8'h02);
		repeat (3) rise(1'b0, c);
		check("sync end", 16'(c), 16'h0020);
		wait_ready(`WT_ST_ENABLE_READY);
		wr(`WT_ADDR_FIRST_CTRL, 8'h00);
		wr(`WT_ADDR_SECOND_CTRL, 8'h00);
		wr(`WT_ADDR_THIRD_CTRL, 8'h01);
		config_change_unlock <= 1'b1;
		wr(`WT_ADDR_FAULT_CTRL, 8'h02);
		config_change_unlock <= 1'b0;
		wait_ready(`WT_ST_ENABLE_READY);
		wr(`WT_ADDR_FIRST_CTRL, 8'h01);
		wait_ready(`WT_ST_BUFFER_READY);
		wr(`WT_ADDR_CLR_B_LO, 8'h0d);
		wr(`WT_ADDR_CLR_B_HI, 8'h00);
		repeat (3) rise(1'b0, c);
		check("auto update", 16'(c), 16'h000e);
		@(posedge sys_clk);
		fault_event <= 1'b1;
		repeat (3) @(posedge sys_clk);
		quiet("sync fault", 14);
		complete_run();
	end
endmodule : waveform_timer_tb

`default_nettype wire
